//--- verilog/oroc_pkg.sv
// package: offsets, field layout, reset values and timing of the output routing block
package oroc_pkg;
  // clock and debounce timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DEB_BASE_MS = 8;
  localparam int unsigned DEB_BASE_CYC = DEB_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_CNT_W = 25;
  localparam logic [2:0] DEB_CODE_NONE = 3'h0;
  localparam logic [2:0] DEB_CODE_STEP = 3'h1;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_OCP = 8'h0B;
  localparam logic [7:0] IDX_LHP = 8'h0C;
  localparam logic [7:0] IDX_RHP = 8'h0D;
  localparam logic [7:0] IDX_LLO = 8'h0E;
  localparam logic [7:0] IDX_STAT = 8'h20;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 8;

  // protection config fields
  localparam int unsigned OCP_EN_BIT = 4;
  localparam int unsigned OCP_DEB_LSB = 1;
  localparam int unsigned OCP_DEB_MSB = 3;
  localparam int unsigned OCP_PDN_BIT = 0;

  // left headphone routing fields
  localparam int unsigned LHP_DACP_BIT = 3;
  localparam int unsigned LHP_IN1_BIT = 2;
  localparam int unsigned LHP_MIXL_BIT = 1;
  localparam int unsigned LHP_MIXR_BIT = 0;

  // right headphone routing fields
  localparam int unsigned RHP_DACLN_BIT = 4;
  localparam int unsigned RHP_DACRP_BIT = 3;
  localparam int unsigned RHP_IN1_BIT = 2;
  localparam int unsigned RHP_MIXR_BIT = 1;
  localparam int unsigned RHP_LHP_BIT = 0;

  // left line output routing fields
  localparam int unsigned LLO_DACRN_BIT = 4;
  localparam int unsigned LLO_DACL_BIT = 3;
  localparam int unsigned LLO_MIXL_BIT = 1;
  localparam int unsigned LLO_RLO_BIT = 0;

  // status fields (trip bits are write-one-to-clear)
  localparam int unsigned STAT_TRIP_L_BIT = 0;
  localparam int unsigned STAT_TRIP_R_BIT = 1;

  // writable masks and reset values
  localparam logic [7:0] OCP_WMASK = 8'h1F;
  localparam logic [7:0] LHP_WMASK = 8'h0F;
  localparam logic [7:0] RHP_WMASK = 8'h1F;
  localparam logic [7:0] LLO_WMASK = 8'h1B;
  localparam logic [7:0] OCP_RST = 8'h10;
  localparam logic [7:0] ROUTE_RST = 8'h00;

  // over-current guard states
  typedef enum logic [1:0] {OROC_IDLE, OROC_WAIT, OROC_TRIP} oroc_guard_st_t;
endpackage

//--- verilog/oroc_reg_if.sv
// interface: register access strobes between the bus slave and the register core
`timescale 1ns/1ps
interface oroc_reg_if;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport bus_side (
    output wr_en,
    output idx,
    output wdata,
    input rdata,
    input hit
  );
  modport core_side (
    input wr_en,
    input idx,
    input wdata,
    output rdata,
    output hit
  );
endinterface

//--- verilog/oroc_apb.sv
// module: apb slave front end, zero-wait access with registered answer
`timescale 1ns/1ps
module oroc_apb (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oroc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // apb answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // register core
  oroc_reg_if.bus_side rif
);
  import oroc_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } oroc_apb_st_t;

  oroc_apb_st_t st_ff;
  oroc_apb_st_t nxt_st;
  logic ok;

  // decode shared by setup and access
  assign rif.idx = paddr[IDX_LSB +: IDX_W];
  assign ok = rif.hit && (paddr[IDX_LSB-1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == 2'h0);
  // write lands only at the completing edge; lane 0 holds all data
  assign rif.wr_en = psel && penable && pwrite && st_ff.pready && !st_ff.pslverr && pstrb[0];
  assign rif.wdata = pwdata[7:0];

  // answer prepared in setup so every apb answer output is a flop; the register strobes stay combinational
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = psel && !penable;
    if (psel && !penable) begin
      nxt_st.pslverr = !ok;
      nxt_st.prdata = (ok && !pwrite) ? {24'h000000, rif.rdata} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign prdata = st_ff.prdata;
endmodule

//--- verilog/oroc_guard.sv
// module: over-current debounce and response for one headphone driver
`timescale 1ns/1ps
module oroc_guard #(
  parameter int unsigned BASE_CYC = oroc_pkg::DEB_BASE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire logic enable,
  input wire logic [2:0] deb_code,
  input wire logic pdown_mode,
  input wire logic release_pdown,
  // sensed condition
  input wire logic oc_raw,
  // response
  output logic limit,
  output logic pdown,
  output logic trip
);
  import oroc_pkg::*;

  typedef struct packed {
    oroc_guard_st_t state;
    logic [DEB_CNT_W-1:0] cnt;
    logic limit;
    logic pdown;
    logic trip;
  } oroc_guard_reg_t;

  oroc_guard_reg_t st_ff;
  oroc_guard_reg_t nxt_st;
  logic [DEB_CNT_W-1:0] target;
  logic [DEB_CNT_W-1:0] base;

  // interval doubles per code step from the base
  assign base = DEB_CNT_W'(BASE_CYC);
  assign target = base << (deb_code - DEB_CODE_STEP);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.trip = 1'b0;
    if (!enable) begin
      nxt_st = '0;
    end else begin
      unique case (st_ff.state)
        OROC_IDLE: begin
          if (oc_raw && deb_code == DEB_CODE_NONE) begin
            nxt_st.state = OROC_TRIP;
            nxt_st.trip = 1'b1;
            nxt_st.limit = !pdown_mode;
            nxt_st.pdown = pdown_mode;
          end else if (oc_raw) begin
            nxt_st.state = OROC_WAIT;
            nxt_st.cnt = {{(DEB_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        OROC_WAIT: begin
          // any gap restarts the interval
          if (!oc_raw) begin
            nxt_st.state = OROC_IDLE;
            nxt_st.cnt = '0;
          // code dropped to none mid-count trips at once instead of using a wrapped shift
          end else if (deb_code == DEB_CODE_NONE || st_ff.cnt >= target - DEB_CNT_W'(1)) begin
            nxt_st.state = OROC_TRIP;
            nxt_st.cnt = '0;
            nxt_st.trip = 1'b1;
            nxt_st.limit = !pdown_mode;
            nxt_st.pdown = pdown_mode;
          end else begin
            nxt_st.cnt = st_ff.cnt + DEB_CNT_W'(1);
          end
        end
        OROC_TRIP: begin
          // limiting follows the condition; power-down holds until software releases it
          if ((!st_ff.pdown && !oc_raw) || (st_ff.pdown && release_pdown)) begin
            nxt_st.state = OROC_IDLE;
            nxt_st.limit = 1'b0;
            nxt_st.pdown = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign limit = st_ff.limit;
  assign pdown = st_ff.pdown;
  assign trip = st_ff.trip;
endmodule

//--- verilog/oroc_top.sv
// module: output routing and headphone over-current control registers behind apb
`timescale 1ns/1ps
// Function
// - enable bit 4 detects both drivers, reset 1
// - bits 3-1 pick debounce, none to 512ms
// - bit 0 limits current or powers down
// - left headphone bit 3 left dac positive
// - left headphone bit 2 first left input
// - left headphone bits 1/0 left/right mixer
// - right headphone bit 4 left dac negative
// - right headphone bit 3 right dac positive
// - right headphone bit 2 first right input
// - right headphone bit 1 right mixer
// - right headphone bit 0 left driver, analog supply
// - left line bit 4 right dac negative
// - left line bit 3 left dac output
// - left line bit 1 left mixer
// - left line bit 0 right line, analog supply
module oroc_top #(
  parameter int unsigned DEB_BASE_CYC = oroc_pkg::DEB_BASE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [oroc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // apb answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // over-current sense from the drivers
  input wire logic left_headphone_driver_oc,
  input wire logic right_headphone_driver_oc,
  // over-current response
  output logic left_headphone_driver_current_limit,
  output logic left_headphone_driver_ocp_power_down,
  output logic right_headphone_driver_current_limit,
  output logic right_headphone_driver_ocp_power_down,
  // left headphone driver sources
  output logic left_headphone_driver_from_left_dac_pos,
  output logic left_headphone_driver_from_first_left_analog_input,
  output logic left_headphone_driver_from_left_mixer_amplifier,
  output logic left_headphone_driver_from_right_mixer_amplifier,
  // right headphone driver sources
  output logic right_headphone_driver_from_left_dac_neg,
  output logic right_headphone_driver_from_right_dac_pos,
  output logic right_headphone_driver_from_first_right_analog_input,
  output logic right_headphone_driver_from_right_mixer_amplifier,
  output logic right_headphone_driver_from_left_headphone_driver,
  // left line output sources
  output logic left_line_output_from_right_dac_neg,
  output logic left_line_output_from_left_dac,
  output logic left_line_output_from_left_mixer_amplifier,
  output logic left_line_output_from_right_line_output
);
  import oroc_pkg::*;

  typedef struct packed {
    logic [7:0] overcurrent_protect_config;
    logic [7:0] left_headphone_routing;
    logic [7:0] right_headphone_routing;
    logic [7:0] left_line_out_routing;
    logic [1:0] trip_seen;
  } oroc_core_st_t;

  oroc_core_st_t st_ff;
  oroc_core_st_t nxt_st;
  oroc_reg_if rif ();

  logic ocp_en;
  logic [2:0] ocp_deb;
  logic ocp_pdn_mode;
  logic [1:0] trip_pulse;
  logic [1:0] lim;
  logic [1:0] pdn;
  logic [1:0] release_pdown;
  logic [1:0] w1c;
  logic ocp_write;

  // bus front end
  oroc_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rif(rif.bus_side)
  );

  // protection fields feeding both guards
  assign ocp_en = st_ff.overcurrent_protect_config[OCP_EN_BIT];
  assign ocp_deb = st_ff.overcurrent_protect_config[OCP_DEB_MSB:OCP_DEB_LSB];
  assign ocp_pdn_mode = st_ff.overcurrent_protect_config[OCP_PDN_BIT];

  // write strobes: clearing a trip bit or rewriting the config frees a powered-down driver
  assign ocp_write = rif.wr_en && rif.idx == IDX_OCP;
  assign w1c[0] = rif.wr_en && rif.idx == IDX_STAT && rif.wdata[STAT_TRIP_L_BIT];
  assign w1c[1] = rif.wr_en && rif.idx == IDX_STAT && rif.wdata[STAT_TRIP_R_BIT];
  assign release_pdown = w1c | {2{ocp_write}};

  // left headphone guard
  oroc_guard #(
    .BASE_CYC(DEB_BASE_CYC)
  ) u_guard_left (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ocp_en),
    .deb_code(ocp_deb),
    .pdown_mode(ocp_pdn_mode),
    .release_pdown(release_pdown[0]),
    .oc_raw(left_headphone_driver_oc),
    .limit(lim[0]),
    .pdown(pdn[0]),
    .trip(trip_pulse[0])
  );

  // right headphone guard, same settings
  oroc_guard #(
    .BASE_CYC(DEB_BASE_CYC)
  ) u_guard_right (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ocp_en),
    .deb_code(ocp_deb),
    .pdown_mode(ocp_pdn_mode),
    .release_pdown(release_pdown[1]),
    .oc_raw(right_headphone_driver_oc),
    .limit(lim[1]),
    .pdown(pdn[1]),
    .trip(trip_pulse[1])
  );

  // register writes; reserved bits are masked off so they always read zero
  always_comb begin
    nxt_st = st_ff;
    if (rif.wr_en) begin
      unique case (rif.idx)
        IDX_OCP: nxt_st.overcurrent_protect_config = rif.wdata & OCP_WMASK;
        IDX_LHP: nxt_st.left_headphone_routing = rif.wdata & LHP_WMASK;
        IDX_RHP: nxt_st.right_headphone_routing = rif.wdata & RHP_WMASK;
        IDX_LLO: nxt_st.left_line_out_routing = rif.wdata & LLO_WMASK;
        default: nxt_st.trip_seen = st_ff.trip_seen;
      endcase
    end
    // sticky trip flags: a new trip in the clearing cycle survives
    nxt_st.trip_seen = (st_ff.trip_seen & ~w1c) | trip_pulse;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.overcurrent_protect_config <= OCP_RST;
      st_ff.left_headphone_routing <= ROUTE_RST;
      st_ff.right_headphone_routing <= ROUTE_RST;
      st_ff.left_line_out_routing <= ROUTE_RST;
      st_ff.trip_seen <= 2'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // read mux, sampled by the bus slave in the setup cycle
  always_comb begin
    rif.hit = 1'b1;
    rif.rdata = 8'h00;
    unique case (rif.idx)
      IDX_OCP: rif.rdata = st_ff.overcurrent_protect_config;
      IDX_LHP: rif.rdata = st_ff.left_headphone_routing;
      IDX_RHP: rif.rdata = st_ff.right_headphone_routing;
      IDX_LLO: rif.rdata = st_ff.left_line_out_routing;
      IDX_STAT: rif.rdata = {2'h0, pdn, lim, st_ff.trip_seen};
      default: rif.hit = 1'b0;
    endcase
  end

  // over-current response straight from the guard flops
  assign left_headphone_driver_current_limit = lim[0];
  assign right_headphone_driver_current_limit = lim[1];
  assign left_headphone_driver_ocp_power_down = pdn[0];
  assign right_headphone_driver_ocp_power_down = pdn[1];

  // left headphone switches
  assign left_headphone_driver_from_left_dac_pos = st_ff.left_headphone_routing[LHP_DACP_BIT];
  assign left_headphone_driver_from_first_left_analog_input = st_ff.left_headphone_routing[LHP_IN1_BIT];
  assign left_headphone_driver_from_left_mixer_amplifier = st_ff.left_headphone_routing[LHP_MIXL_BIT];
  assign left_headphone_driver_from_right_mixer_amplifier = st_ff.left_headphone_routing[LHP_MIXR_BIT];

  // right headphone switches; supply check is software's job
  assign right_headphone_driver_from_left_dac_neg = st_ff.right_headphone_routing[RHP_DACLN_BIT];
  assign right_headphone_driver_from_right_dac_pos = st_ff.right_headphone_routing[RHP_DACRP_BIT];
  assign right_headphone_driver_from_first_right_analog_input = st_ff.right_headphone_routing[RHP_IN1_BIT];
  assign right_headphone_driver_from_right_mixer_amplifier = st_ff.right_headphone_routing[RHP_MIXR_BIT];
  assign right_headphone_driver_from_left_headphone_driver = st_ff.right_headphone_routing[RHP_LHP_BIT];

  // left line output switches
  assign left_line_output_from_right_dac_neg = st_ff.left_line_out_routing[LLO_DACRN_BIT];
  assign left_line_output_from_left_dac = st_ff.left_line_out_routing[LLO_DACL_BIT];
  assign left_line_output_from_left_mixer_amplifier = st_ff.left_line_out_routing[LLO_MIXL_BIT];
  assign left_line_output_from_right_line_output = st_ff.left_line_out_routing[LLO_RLO_BIT];
endmodule

//--- sim/oroc_sva.sv
// checker: register effects and over-current response at the routing block pins
`timescale 1ns/1ps
module oroc_sva #(
  parameter int unsigned DEB_BASE_CYC = oroc_pkg::DEB_BASE_CYC
) (
  // clock, reset and bus
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [oroc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // over-current sense and response
  input wire logic left_headphone_driver_oc, right_headphone_driver_oc,
  input wire logic left_headphone_driver_current_limit, right_headphone_driver_ocp_power_down,
  // routing outputs
  input wire logic left_headphone_driver_from_left_dac_pos, left_headphone_driver_from_first_left_analog_input,
  input wire logic left_headphone_driver_from_left_mixer_amplifier, left_headphone_driver_from_right_mixer_amplifier,
  input wire logic right_headphone_driver_from_left_dac_neg, right_headphone_driver_from_right_dac_pos,
  input wire logic right_headphone_driver_from_first_right_analog_input,
  input wire logic right_headphone_driver_from_right_mixer_amplifier,
  input wire logic right_headphone_driver_from_left_headphone_driver,
  input wire logic left_line_output_from_right_dac_neg, left_line_output_from_left_dac,
  input wire logic left_line_output_from_left_mixer_amplifier, left_line_output_from_right_line_output
);
  import oroc_pkg::*;
  logic wr_ok;
  logic [4:0] ocp_ff;
  logic [31:0] run_ff;
  logic [31:0] deb_tgt;
  logic [12:0] route;
  // accepted write, debounce target and all routing pins in one vector
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  assign deb_tgt = (ocp_ff[3:1] == 3'h0) ? 32'h1 : 32'(DEB_BASE_CYC) << (ocp_ff[3:1] - 3'h1);
  assign route = {left_headphone_driver_from_left_dac_pos, left_headphone_driver_from_first_left_analog_input,
    left_headphone_driver_from_left_mixer_amplifier, left_headphone_driver_from_right_mixer_amplifier,
    right_headphone_driver_from_left_dac_neg, right_headphone_driver_from_right_dac_pos,
    right_headphone_driver_from_first_right_analog_input, right_headphone_driver_from_right_mixer_amplifier,
    right_headphone_driver_from_left_headphone_driver, left_line_output_from_right_dac_neg,
    left_line_output_from_left_dac, left_line_output_from_left_mixer_amplifier,
    left_line_output_from_right_line_output};
  // config mirror and left sense run length; bench keeps config fixed while sense is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocp_ff <= 5'h10;
      run_ff <= 32'h0;
    end else begin
      if (wr_ok && paddr == 12'h02C) ocp_ff <= pwdata[4:0];
      run_ff <= left_headphone_driver_oc ? run_ff + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_route_left_hp: assert property (wr_ok && paddr == 12'h030 |=> route[12:9] == $past(pwdata[3:0]))
    else $error("left headphone routing pins differ from write");
  a_route_right_hp: assert property (wr_ok && paddr == 12'h034 |=> route[8:4] == $past(pwdata[4:0]))
    else $error("right headphone routing pins differ from write");
  a_route_line_out: assert property (wr_ok && paddr == 12'h038 |=> route[3:0] == $past({pwdata[4:3], pwdata[1:0]}))
    else $error("line output routing pins differ from write");
  a_route_hold: assert property (!wr_ok |=> $stable(route))
    else $error("routing pins moved without a write");
  a_oc_fast_limit: assert property (ocp_ff == 5'h10 && left_headphone_driver_oc |=> left_headphone_driver_current_limit)
    else $error("no current limit after undebounced over-current");
  a_oc_pdown_mode: assert property (ocp_ff == 5'h11 && right_headphone_driver_oc && !wr_ok |=> right_headphone_driver_ocp_power_down)
    else $error("no power-down after over-current");
  a_oc_disabled: assert property (!ocp_ff[4] |=> !left_headphone_driver_current_limit && !right_headphone_driver_ocp_power_down)
    else $error("response while detection disabled");
  a_deb_min_run: assert property ($rose(left_headphone_driver_current_limit) |-> run_ff >= deb_tgt)
    else $error("limit before debounce interval");
  a_limit_release: assert property (!left_headphone_driver_oc [*2] |-> !left_headphone_driver_current_limit)
    else $error("limit held after sense dropped");
  c_deb_long: cover property (ocp_ff[3:1] == 3'h7 && $rose(left_headphone_driver_current_limit));
  c_pdown: cover property ($rose(right_headphone_driver_ocp_power_down));
  c_line_write: cover property (wr_ok && paddr == 12'h038);
endmodule

//--- sim/oroc_drv_model.sv
// model: headphone drivers that report over-current while a surge is applied
`timescale 1ns/1ps
module oroc_drv_model (
  // clock
  input wire logic pclk,
  // driver state from the block
  input wire logic left_pdown,
  input wire logic right_pdown,
  // sensed over-current
  output logic left_oc,
  output logic right_oc
);
  logic [1:0] surge_ff = 2'h0;
  // a powered-down driver draws no current, so its sense drops at once
  assign left_oc = surge_ff[0] && !left_pdown;
  assign right_oc = surge_ff[1] && !right_pdown;
  // hold a surge on one side (0 left, 1 right) for n sampled edges
  task automatic surge(input int side, input int n);
    // a zero-length surge would raise and drop the sense in one time step
    if (n == 0) return;
    @(posedge pclk);
    surge_ff[side] <= 1'b1;
    repeat (n) @(posedge pclk);
    surge_ff[side] <= 1'b0;
  endtask
endmodule

//--- sim/testbench.sv
// testbench: register access, routing and over-current scenarios of the routing block
`timescale 1ns/1ps
module testbench;
  import oroc_pkg::*;
  localparam int unsigned DEB = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, seen_l;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0] pstrb, resp;
  logic [1:0] oc;
  logic [12:0] route, exp_rt;
  logic [32:0] expq[$];
  logic [32:0] exp_n;
  logic [15:0] lfsr_ff;
  logic [7:0] msk [3] = '{8'h0F, 8'h1F, 8'h1B};
  int fails = 0, n_compared = 0, cyc = 0, tgt;
  oroc_top #(.DEB_BASE_CYC(DEB)) uut (.*,
    .left_headphone_driver_oc(oc[0]), .right_headphone_driver_oc(oc[1]),
    .left_headphone_driver_current_limit(resp[0]), .left_headphone_driver_ocp_power_down(resp[1]),
    .right_headphone_driver_current_limit(resp[2]), .right_headphone_driver_ocp_power_down(resp[3]),
    .left_headphone_driver_from_left_dac_pos(route[12]), .left_headphone_driver_from_first_left_analog_input(route[11]),
    .left_headphone_driver_from_left_mixer_amplifier(route[10]),
    .left_headphone_driver_from_right_mixer_amplifier(route[9]), .right_headphone_driver_from_left_dac_neg(route[8]),
    .right_headphone_driver_from_right_dac_pos(route[7]),
    .right_headphone_driver_from_first_right_analog_input(route[6]),
    .right_headphone_driver_from_right_mixer_amplifier(route[5]),
    .right_headphone_driver_from_left_headphone_driver(route[4]), .left_line_output_from_right_dac_neg(route[3]),
    .left_line_output_from_left_dac(route[2]), .left_line_output_from_left_mixer_amplifier(route[1]),
    .left_line_output_from_right_line_output(route[0]));
  oroc_drv_model drv (.pclk(pclk), .left_pdown(resp[1]), .right_pdown(resp[3]), .left_oc(oc[0]), .right_oc(oc[1]));
  // free-running 25 ns clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer; exp holds the error flag above the read data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                     input logic [32:0] exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    expq.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // answer monitor, sticky trip flag and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (resp[0] === 1'b1) seen_l <= 1'b1;
    if (psel && penable && pready === 1'b1) begin
      exp_n = expq.pop_front();
      check("prdata", prdata, exp_n[31:0]);
      check("pslverr", {31'h0, pslverr}, {31'h0, exp_n[32]});
    end
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, seen_l, presetn} = '0;
    lfsr_ff = 16'h5DF9;
    exp_rt = 13'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h02C, 32'h0, 4'hF, {1'b0, 32'h10});
    for (int i = 0; i < 3; i++) apb(1'b0, 12'h030 + 12'(4 * i), 32'h0, 4'hF, 33'h0);
    // random routing patterns; software keeps reserved bits at zero
    for (int i = 0; i < 12; i++) begin
      lfsr_ff = lfsr(lfsr_ff);
      d = {24'h0, lfsr_ff[7:0] & msk[i % 3]};
      apb(1'b1, 12'h030 + 12'(4 * (i % 3)), d, 4'hF, 33'h0);
      apb(1'b0, 12'h030 + 12'(4 * (i % 3)), 32'h0, 4'hF, {1'b0, d});
      if (i % 3 == 0) exp_rt[12:9] = d[3:0];
      else if (i % 3 == 1) exp_rt[8:4] = d[4:0];
      else exp_rt[3:0] = {d[4:3], d[1:0]};
      check("route", {19'h0, route}, {19'h0, exp_rt});
    end
    // a write with lane 0 off is dropped, an unmapped word answers with an error
    apb(1'b1, 12'h038, 32'hFF, 4'h0, 33'h0);
    check("route", {19'h0, route}, {19'h0, exp_rt});
    apb(1'b0, 12'h03C, 32'h0, 4'hF, {1'b1, 32'h0});
    // misaligned and out-of-range addresses answer with an error as well
    apb(1'b0, 12'h02D, 32'h0, 4'hF, {1'b1, 32'h0});
    apb(1'b0, 12'h42C, 32'h0, 4'hF, {1'b1, 32'h0});
    // each debounce code: one sample short must not trip, a full run must
    for (int c = 0; c < 8; c++) begin
      tgt = (c == 0) ? 1 : DEB << (c - 1);
      apb(1'b1, 12'h02C, {27'h0, 1'b1, 3'(c), 1'b0}, 4'hF, 33'h0);
      seen_l = 1'b0;
      drv.surge(0, tgt - 1);
      repeat (4) @(posedge pclk);
      check("early trip", {31'h0, seen_l}, 32'h0);
      drv.surge(0, tgt + 2);
      check("debounced trip", {31'h0, seen_l}, 32'h1);
      repeat (4) @(posedge pclk);
      check("limit released", {28'h0, resp}, 32'h0);
    end
    // right limit, then power-down on both sides; left trip flag is still sticky from the loop
    apb(1'b1, 12'h02C, 32'h10, 4'hF, 33'h0);
    drv.surge(1, 3);
    check("right limit", {28'h0, resp}, 32'h4);
    apb(1'b1, 12'h02C, 32'h11, 4'hF, 33'h0);
    drv.surge(1, 3);
    check("power down", {28'h0, resp}, 32'h8);
    drv.surge(0, 3);
    check("power down both", {28'h0, resp}, 32'hA);
    apb(1'b0, 12'h080, 32'h0, 4'hF, {1'b0, 32'h33});
    // clearing the right flag frees the right driver, rewriting the config frees the left
    apb(1'b1, 12'h080, 32'h2, 4'hF, 33'h0);
    apb(1'b1, 12'h02C, 32'h11, 4'hF, 33'h0);
    apb(1'b0, 12'h080, 32'h0, 4'hF, {1'b0, 32'h01});
    // detection off: a long surge draws no response
    apb(1'b1, 12'h02C, 32'h0, 4'hF, 33'h0);
    seen_l = 1'b0;
    drv.surge(0, 5);
    repeat (2) @(posedge pclk);
    check("disabled", {27'h0, seen_l, resp}, 32'h0);
    // second reset in mid-run restores defaults
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h02C, 32'h0, 4'hF, {1'b0, 32'h10});
    check("route after reset", {19'h0, route}, 32'h0);
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule
bind oroc_top oroc_sva #(.DEB_BASE_CYC(DEB_BASE_CYC)) u_sva (.*);
